/* File: flash_spi_pkg.sv */
// Shared constants and types for the flash SPI command block
package flash_spi_pkg;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_FULL_ERASE = 8'h60;
  localparam logic [7:0] CMD_WRITE_ENABLE_SET_CMD_SET = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam int CMD_BITS = 8;
  localparam int WIDE_ADDR_BITS = 16;
  localparam int NARROW_ADDR_BITS = 8;
  localparam int WIDE_DATA_BITS = 16;
  localparam int NARROW_DATA_BITS = 8;
  localparam int FLASH_ADDR_BITS = 9;
  localparam int SECTOR_BIT = 8;
  localparam int STATUS_BITS = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_WEN = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_SECTOR_ERASE = 2'h1;
  localparam logic [1:0] OP_FULL_ERASE = 2'h2;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [1:0] op;
    logic [8:0] addr;
    logic [15:0] data;
  } flash_req_t;
  localparam int REQ_W = 27;
endpackage : flash_spi_pkg

/* File: flash_req_fifo.sv */
// Request FIFO between the serial front end and the flash port
`timescale 1ns/1ns
module flash_req_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : flash_req_fifo

/* File: sync_2ff.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync_2ff #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : sync_2ff

/* File: flash_spi_write_erase_status.sv */
// SPI slave command logic for user flash write, erase and status
`timescale 1ns/1ns
// Behaviour
// RULE1: Master writes only to erased FFFF words
// RULE2: All serial fields shift MSB first
// RULE3: Flash operation starts after chip select rises
// RULE4: Wide write: 02, 16-bit address, keep nine
// RULE5: Write command ignored while flash busy
// RULE6: Enable and protect check gates data stage
// RULE7: Wide write carries one 16-bit data word
// RULE8: Narrow write: 02, 8-bit address, byte
// RULE9: Sector erase 20 picks sector by bit eight
// RULE10: Sector erase needs enable, unprotected sector
// RULE11: Narrow sector erase always hits sector zero
// RULE12: Full erase 60 hits all variant sectors
// RULE13: Full erase needs enable, no protection
// RULE14: Busy flag held for whole flash cycle
// RULE15: Write enable cleared at power-up
// RULE16: Enable set by 06, cleared only by 04
// RULE17: After enable commands ignore input until deselect
// RULE18: Write disable 04 clears write enable
// RULE19: Read-only build: no status, no enable
// RULE20: Status read 05 repeats byte MSB first
// RULE21: While busy only status read is recognised
// RULE22: Status write 01 updates only protect bits
// RULE23: Status write needs exactly eight data bits
// RULE24: Protect 11 covers whole variant address range
// RULE25: Status bits: busy, enable, protect, zeros
// RULE26: Sample on rising, drive on falling clock
// RULE27: Invalid command ignored until chip select high
// RULE28: Protect codes 01 and 10 mean full protection
// RULE29: Serial output released when idle or deselected
module flash_spi_write_erase_status #(
  parameter bit WIDE_MODE = 1'b1,
  parameter bit READ_ONLY = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sck,
  input wire logic i_spi_si,
  output logic o_spi_so,
  output logic o_spi_so_oe_n,
  input wire logic i_flash_busy,
  output logic o_flash_req_valid,
  input wire logic i_flash_req_ready,
  output flash_spi_pkg::flash_req_t o_flash_req,
  output logic [7:0] o_status
);
  typedef enum logic [6:0] {
    ST_CMD = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_DATA = 7'b0000100,
    ST_SRD = 7'b0001000,
    ST_SWR = 7'b0010000,
    ST_WAIT = 7'b0100000,
    ST_SWR_DONE = 7'b1000000
  } spi_state_t;

  localparam int ADDR_BITS = WIDE_MODE ? flash_spi_pkg::WIDE_ADDR_BITS
                                       : flash_spi_pkg::NARROW_ADDR_BITS;
  localparam int DATA_BITS = WIDE_MODE ? flash_spi_pkg::WIDE_DATA_BITS
                                       : flash_spi_pkg::NARROW_DATA_BITS;

  logic [2:0] pins_sync;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic sck_prev_reg;
  logic cs_prev_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  spi_state_t state_reg;
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] cmd_reg;
  logic [8:0] addr_reg;
  logic [15:0] data_reg;
  logic pend_reg;
  logic [1:0] pend_op_reg;
  logic wen_reg;
  logic bp_hi_reg;
  logic bp_lo_reg;
  logic busy_reg;
  logic [7:0] so_shift_reg;
  logic [2:0] so_cnt_reg;
  logic so_oe_n_reg;
  logic so_reg;
  logic q_valid_reg;
  flash_spi_pkg::flash_req_t q_data_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  flash_spi_pkg::flash_req_t fifo_out_data;
  logic out_valid_reg;
  flash_spi_pkg::flash_req_t out_req_reg;
  logic [7:0] status_byte;
  logic protected_any;
  logic [15:0] shift_next;
  logic [4:0] bit_cnt_next;

  sync_2ff #(
    .WIDTH(3),
    .RESET_VAL(3'h5)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async({i_spi_cs_n, i_spi_sck, i_spi_si}),
    .o_sync(pins_sync)
  );
  assign cs_n_s = pins_sync[2];
  assign sck_s = pins_sync[1];
  assign si_s = pins_sync[0];

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_n_s;
    end
  end
  assign sck_rise = !cs_n_s && sck_s && !sck_prev_reg; // RULE26
  assign sck_fall = !cs_n_s && !sck_s && sck_prev_reg; // RULE26
  assign cs_rise = cs_n_s && !cs_prev_reg;

  // Any non-zero protect code protects everything
  assign protected_any = bp_hi_reg || bp_lo_reg; // RULE24 RULE28
  assign status_byte = {4'h0, bp_hi_reg, bp_lo_reg, wen_reg, busy_reg}; // RULE25
  assign shift_next = {shift_reg[14:0], si_s}; // RULE2
  assign bit_cnt_next = bit_cnt_reg + 5'h01;

  // Busy covers pending, queued and running flash work
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= pend_reg || q_valid_reg || fifo_out_valid || out_valid_reg
                  || i_flash_busy; // RULE14
    end
  end

  // Serial command decoder
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_CMD;
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      addr_reg <= 9'h000;
      data_reg <= 16'h0000;
      pend_reg <= 1'b0;
      pend_op_reg <= flash_spi_pkg::OP_WRITE;
    end else if (cs_n_s) begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 5'h00;
      pend_reg <= 1'b0;
    end else if (sck_rise) begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      case (state_reg)
        ST_CMD: begin
          if (bit_cnt_next == 5'(flash_spi_pkg::CMD_BITS)) begin
            bit_cnt_reg <= 5'h00;
            cmd_reg <= shift_next[7:0];
            state_reg <= ST_WAIT; // RULE27
            if (shift_next[7:0] == flash_spi_pkg::CMD_STATUS_READ
                && !READ_ONLY) begin
              state_reg <= ST_SRD;
            end else if (!busy_reg && !READ_ONLY) begin // RULE21 RULE19
              case (shift_next[7:0])
                flash_spi_pkg::CMD_WRITE: state_reg <= ST_ADDR; // RULE5
                flash_spi_pkg::CMD_SECTOR_ERASE: begin
                  if (WIDE_MODE) begin
                    state_reg <= ST_ADDR;
                  end else begin
                    addr_reg <= 9'h000; // RULE11
                    pend_reg <= wen_reg && !protected_any; // RULE10
                    pend_op_reg <= flash_spi_pkg::OP_SECTOR_ERASE;
                  end
                end
                flash_spi_pkg::CMD_FULL_ERASE: begin
                  addr_reg <= 9'h000;
                  pend_reg <= wen_reg && !protected_any; // RULE13
                  pend_op_reg <= flash_spi_pkg::OP_FULL_ERASE; // RULE12
                end
                flash_spi_pkg::CMD_STATUS_WRITE: state_reg <= ST_SWR;
                default: state_reg <= ST_WAIT; // RULE17
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (bit_cnt_next == 5'(ADDR_BITS)) begin
            bit_cnt_reg <= 5'h00;
            // Only the low nine bits survive in wide mode
            addr_reg <= WIDE_MODE ? shift_next[8:0]
                                  : {1'b0, shift_next[7:0]}; // RULE4 RULE8
            if (cmd_reg == flash_spi_pkg::CMD_SECTOR_ERASE) begin
              state_reg <= ST_WAIT;
              pend_reg <= wen_reg && !protected_any; // RULE9 RULE10
              pend_op_reg <= flash_spi_pkg::OP_SECTOR_ERASE;
            end else if (wen_reg && !protected_any) begin // RULE6
              state_reg <= ST_DATA;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_DATA: begin
          if (bit_cnt_next == 5'(DATA_BITS)) begin // RULE7 RULE8
            data_reg <= WIDE_MODE ? shift_next : {8'hFF, shift_next[7:0]};
            pend_reg <= 1'b1;
            pend_op_reg <= flash_spi_pkg::OP_WRITE;
            state_reg <= ST_WAIT;
          end
        end
        ST_SWR: begin
          if (bit_cnt_next == 5'(flash_spi_pkg::STATUS_BITS)) begin
            data_reg <= {8'h00, shift_next[7:0]};
            state_reg <= ST_SWR_DONE;
          end
        end
        ST_SWR_DONE: state_reg <= ST_WAIT; // RULE23
        ST_SRD: state_reg <= ST_SRD; // RULE20
        ST_WAIT: state_reg <= ST_WAIT; // RULE17
        default: state_reg <= ST_WAIT;
      endcase
    end
  end

  // Enable and protect bits, frozen while busy
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wen_reg <= 1'b0; // RULE15
      bp_hi_reg <= 1'b0; // RULE22
      bp_lo_reg <= 1'b0;
    end else if (sck_rise && state_reg == ST_CMD && !busy_reg
                 && !READ_ONLY && bit_cnt_next == 5'(flash_spi_pkg::CMD_BITS)) begin
      if (shift_next[7:0] == flash_spi_pkg::CMD_WRITE_ENABLE_SET_CMD_SET) begin
        wen_reg <= 1'b1; // RULE16
      end else if (shift_next[7:0] == flash_spi_pkg::CMD_WR_DISABLE) begin
        wen_reg <= 1'b0; // RULE18
      end
    end else if (cs_rise && state_reg == ST_SWR_DONE && !busy_reg) begin
      bp_hi_reg <= data_reg[flash_spi_pkg::ST_BP_HI]; // RULE22 RULE23
      bp_lo_reg <= data_reg[flash_spi_pkg::ST_BP_LO];
    end
  end

  // Flash work is handed over only at deselect
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      q_valid_reg <= 1'b0;
      q_data_reg <= '0;
    end else if (cs_rise && pend_reg) begin
      q_valid_reg <= 1'b1; // RULE3
      q_data_reg <= '{op: pend_op_reg, addr: addr_reg, data: data_reg}; // RULE1
    end else if (fifo_in_ready) begin
      q_valid_reg <= 1'b0;
    end
  end

  flash_req_fifo #(
    .WIDTH(flash_spi_pkg::REQ_W),
    .DEPTH(flash_spi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(q_valid_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(q_data_reg),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(!out_valid_reg || i_flash_req_ready),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      out_valid_reg <= 1'b0;
      out_req_reg <= '0;
    end else if (!out_valid_reg || i_flash_req_ready) begin
      out_valid_reg <= fifo_out_valid;
      out_req_reg <= fifo_out_data;
    end
  end

  // Status byte output on falling serial clock edges
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      so_shift_reg <= 8'h00;
      so_cnt_reg <= 3'h0;
      so_oe_n_reg <= 1'b1;
      so_reg <= 1'b0;
    end else if (state_reg != ST_SRD || cs_n_s) begin
      so_oe_n_reg <= 1'b1; // RULE29
      so_cnt_reg <= 3'h0;
      so_shift_reg <= status_byte;
    end else if (sck_fall) begin
      so_oe_n_reg <= 1'b0;
      so_reg <= (so_cnt_reg == 3'h0) ? status_byte[7] : so_shift_reg[7]; // RULE20
      so_shift_reg <= (so_cnt_reg == 3'h0) ? {status_byte[6:0], 1'b0}
                                          : {so_shift_reg[6:0], 1'b0};
      so_cnt_reg <= so_cnt_reg + 3'h1;
    end
  end

  assign o_spi_so = so_reg;
  assign o_spi_so_oe_n = so_oe_n_reg;
  assign o_flash_req_valid = out_valid_reg;
  assign o_flash_req = out_req_reg;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_status <= 8'h00;
    end else begin
      o_status <= status_byte;
    end
  end
endmodule : flash_spi_write_erase_status

/* File: flash_spi_write_erase_status_monitor.sv */
// Assertion checker on the flash SPI block ports
`timescale 1ns/1ns
module flash_spi_write_erase_status_monitor (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_so_oe_n,
  input wire logic o_flash_req_valid,
  input wire logic i_flash_req_ready,
  input wire flash_spi_pkg::flash_req_t o_flash_req,
  input wire logic [7:0] o_status
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  oe_idle_a: assert property (i_spi_cs_n [*5] |-> o_spi_so_oe_n)
    else $error("so driven while deselected");
  st_zero_a: assert property (o_status[7:4] == 4'h0)
    else $error("status high bits set");
  req_hold_a: assert property (o_flash_req_valid && !i_flash_req_ready
    |=> o_flash_req_valid && $stable(o_flash_req))
    else $error("request dropped or changed");
  req_after_cs_a: assert property ($rose(o_flash_req_valid)
    |-> i_spi_cs_n && $past(i_spi_cs_n, 4))
    else $error("request before deselect");
  busy_shown_a: assert property (o_flash_req_valid |-> o_status[0])
    else $error("busy missing");
  frozen_a: assert property (o_status[0] && $past(o_status[0])
    |-> o_status[3:1] == $past(o_status[3:1]))
    else $error("status changed while busy");
  gate_a: assert property ($rose(o_flash_req_valid)
    |-> o_status[3:1] == 3'h1)
    else $error("request without enable or with protection");
  ferase_addr_a: assert property (o_flash_req_valid
    && o_flash_req.op == flash_spi_pkg::OP_FULL_ERASE
    |-> o_flash_req.addr == 9'h000)
    else $error("full erase address not zero");
  cover property (o_flash_req_valid && i_flash_req_ready);
  cover property (!o_spi_so_oe_n);
  cover property ($fell(o_status[0]));
endmodule : flash_spi_write_erase_status_monitor

/* File: spi_master_model.sv */
// Serial master model that frames commands for the flash SPI block
`timescale 1ns/1ns
module spi_master_model (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // Shifts n bits of d; rd keeps the last 16 bits seen on so
  task automatic xfer(input logic [39:0] d, input int n,
                      output logic [15:0] rd);
    rd = 16'h0000;
    o_cs_n = 1'b0;
    #760;
    for (int k = n - 1; k >= 0; k--) begin
      o_sck = 1'b0;
      o_si = d[k];
      #40;
      o_sck = 1'b1;
      #40;
      rd = {rd[14:0], i_so_oe_n ? 1'bz : i_so};
    end
    o_sck = 1'b0;
    #60;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #600;
  endtask : xfer
endmodule : spi_master_model

/* File: flash_spi_write_erase_status_bench.sv */
// Self-checking bench for the flash SPI command block
`timescale 1ns/1ns
module flash_spi_write_erase_status_bench;
  typedef struct packed {
    logic [39:0] d;
    logic [5:0] n;
    logic want;
    logic [26:0] mask;
    logic [26:0] req;
    logic [7:0] st;
  } row_t;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic cs_n, sck, si, so, so_oe_n, req_valid;
  logic ready = 1'b1;
  logic [7:0] bcnt = 8'h00;
  logic [7:0] status;
  logic [15:0] rd;
  logic ro_valid;
  logic [7:0] ro_status;
  int ro_reqs = 0;
  flash_spi_pkg::flash_req_t req, got;
  int reqs = 0;
  int cnt;
  int fail_count = 0;
  int samples_checked = 0;
  row_t rows [15] = '{
    '{40'h02FF05A55A, 6'h28, 1'b0, 27'h0, 27'h0, 8'h00},
    '{40'h06FF, 6'h10, 1'b0, 27'h0, 27'h0, 8'h02},
    '{40'h02FF05A55A, 6'h28, 1'b1, 27'h7FFFFFF, 27'h105A55A, 8'h02},
    '{40'h200100, 6'h18, 1'b1, 27'h7000000, 27'h3000000, 8'h02},
    '{40'h2000FF, 6'h18, 1'b1, 27'h7000000, 27'h2000000, 8'h02},
    '{40'h60, 6'h08, 1'b1, 27'h7FF0000, 27'h4000000, 8'h02},
    '{40'h01CD, 6'h10, 1'b0, 27'h0, 27'h0, 8'h0E},
    '{40'h02FF05A55A, 6'h28, 1'b0, 27'h0, 27'h0, 8'h0E},
    '{40'h200000, 6'h18, 1'b0, 27'h0, 27'h0, 8'h0E},
    '{40'h0104, 6'h10, 1'b0, 27'h0, 27'h0, 8'h06},
    '{40'h60, 6'h08, 1'b0, 27'h0, 27'h0, 8'h06},
    '{40'h00201, 6'h11, 1'b0, 27'h0, 27'h0, 8'h06},
    '{40'h0100, 6'h10, 1'b0, 27'h0, 27'h0, 8'h02},
    '{40'hFF02FF05A5, 6'h28, 1'b0, 27'h0, 27'h0, 8'h02},
    '{40'h04, 6'h08, 1'b0, 27'h0, 27'h0, 8'h00}
  };
  flash_spi_write_erase_status #(.WIDE_MODE(1'b1), .READ_ONLY(1'b0)) i_dut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_cs_n(cs_n),
    .i_spi_sck(sck), .i_spi_si(si), .o_spi_so(so), .o_spi_so_oe_n(so_oe_n),
    .i_flash_busy(bcnt != 8'h00), .o_flash_req_valid(req_valid),
    .i_flash_req_ready(ready), .o_flash_req(req), .o_status(status));
  // Narrow read-only build sees the same frames and must stay inert
  flash_spi_write_erase_status #(.WIDE_MODE(1'b0), .READ_ONLY(1'b1)) i_dut_ro (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_cs_n(cs_n),
    .i_spi_sck(sck), .i_spi_si(si), .o_spi_so(), .o_spi_so_oe_n(),
    .i_flash_busy(1'b0), .o_flash_req_valid(ro_valid),
    .i_flash_req_ready(1'b1), .o_flash_req(), .o_status(ro_status));
  always @(posedge i_sys_clk) begin
    if (ro_valid === 1'b1) begin
      ro_reqs <= ro_reqs + 1;
    end
  end
  spi_master_model i_master (.o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .i_so(so), .i_so_oe_n(so_oe_n));
  always #5 i_sys_clk = ~i_sys_clk;
  // Flash macro stand-in: takes a request, then stays busy 30 cycles
  always @(posedge i_sys_clk) begin
    if (req_valid && ready) begin
      got <= req;
      reqs <= reqs + 1;
      bcnt <= 8'h1E;
    end else if (bcnt != 8'h00) begin
      bcnt <= bcnt - 8'h01;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic settle();
    int t = 0;
    repeat (20) @(posedge i_sys_clk);
    while (status[0] !== 1'b0 && t < 300) begin
      @(posedge i_sys_clk);
      t++;
    end
    #1;
  endtask : settle
  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    #1;
    foreach (rows[i]) begin
      cnt = reqs;
      i_master.xfer(rows[i].d, rows[i].n, rd);
      settle();
      chk("req count", reqs - cnt, {31'h0, rows[i].want});
      if (rows[i].want) begin
        chk("request", got & rows[i].mask, rows[i].req);
      end
      chk("status", status, rows[i].st);
    end
    i_master.xfer(40'h06, 6'h08, rd);
    settle();
    i_master.xfer({24'h0, 8'h05, 16'hA5A5}, 6'h18, rd);
    chk("status read", rd, 16'h0202);
    // Request held by a stalled flash port keeps the block busy
    ready = 1'b0;
    cnt = reqs;
    i_master.xfer(40'h02FF05A55A, 6'h28, rd);
    i_master.xfer(40'h04, 6'h08, rd);
    i_master.xfer(40'h02FF070000, 6'h28, rd);
    i_master.xfer({24'h0, 8'h05, 16'h0000}, 6'h18, rd);
    chk("busy status", rd, 16'h0303);
    ready = 1'b1;
    settle();
    chk("busy req count", reqs - cnt, 32'h1);
    chk("after busy", status, 8'h02);
    i_master.xfer(40'h010C, 6'h10, rd);
    chk("protect set", status, 8'h0E);
    chk("ro status", ro_status, 8'h00);
    chk("ro req count", ro_reqs, 32'h0);
    i_reset = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk("reset status", status, 8'h00);
    chk("so released", so_oe_n, 1'b1);
    test_done();
  end
  initial begin
    #500000;
    fail_count++;
    test_done();
  end
endmodule : flash_spi_write_erase_status_bench
bind flash_spi_write_erase_status flash_spi_write_erase_status_monitor
  i_mon (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_cs_n(i_spi_cs_n),
  .o_spi_so_oe_n(o_spi_so_oe_n), .o_flash_req_valid(o_flash_req_valid),
  .i_flash_req_ready(i_flash_req_ready), .o_flash_req(o_flash_req),
  .o_status(o_status));
